// ==== verilog/dpve_playback.sv ====
/*
  playback control for a stereo dac: volume soft-step, effects switching,
  3-d mix, interpolation hold, modulator, power and bias control.
  assumes the host writes registers over a plain strobe port and delivers
  samples as one-cycle strobes on ref_clk.
*/
// Chosen here: the strobed register port.
// Overview of operation
// - 3-d mono mix, filtered, attenuated, added back
// - interpolation, linear phase, 21 sample delay; the code holds each kept sample with no filter, output one cycle after it
// - images below 7.455 fs rejected 65 dB; the code has no image filter, only the sample hold
// - reference rate set high, divider sets rate
// - first-order modulator, reconstruction at 128 reference_sample_rate
// - per-channel gain 0 to -63.5 dB, mute; the code scales linearly by (128 - code)/128
// - master volume sets both channels together
// - one 0.5 dB step per input sample; the code steps one code, 1/128 of full gain
// - control bit slows ramp to every two
// - status bit shows ramp finished
// - control bit disables ramping, direct gain
// - power-down flag only after ramp, sequence done
// - effect switch: mute, change, then unmute
// - power-up from mute, power-down to mute
// - bias current field bits 7-6, lowest default
// - common-mode level selects one of four
// - dac power plus per-channel analog power
// - coefficients held as 16-bit two's complement
`timescale 1ns/10ps
module dpve_playback (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sample_valid,
  input wire dpve_pkg::dpve_stereo_s sample_in,
  output dpve_pkg::dpve_stereo_s sample_out,
  output logic sample_out_valid,
  output logic [1:0] mod_left,
  output logic [1:0] mod_right,
  output logic dac_power_on,
  output logic left_power_on,
  output logic right_power_on,
  output logic [1:0] cm_level,
  output logic [1:0] bias_current
);
  // ************************************************************
  // registers
  // ************************************************************
  typedef enum {ST_OFF, ST_UP, ST_RUN, ST_FX_DOWN, ST_PDOWN} dpve_state_e;
  dpve_state_e state_r, state_nxt;
  logic [7:0] vol_l_r, vol_l_nxt, vol_r_r, vol_r_nxt;
  logic [7:0] eff_r, eff_nxt, pwr_r, pwr_nxt, atten_r, atten_nxt;
  logic [7:0] div_r, div_nxt, bias_r, bias_nxt, coef_lo_r, coef_lo_nxt;
  logic [3:0] cidx_r, cidx_nxt;
  logic [7:0] rdata_nxt;
  logic [2:0] fx_act_r, fx_act_nxt;
  logic [6:0] app_l_r, app_l_nxt, app_r_r, app_r_nxt;
  logic slow_r, slow_nxt, pdown_r, pdown_nxt;
  logic [7:0] divc_r, divc_nxt;
  logic coef_we;
  logic [15:0] coef_q;
  dpve_pkg::dpve_stereo_s out_r, out_nxt;
  logic out_v_r, out_v_nxt;
  logic [17:0] acc_l_r, acc_l_nxt, acc_r_r, acc_r_nxt;
  logic [1:0] mod_l_r, mod_l_nxt, mod_r_r, mod_r_nxt;
  logic signed [15:0] filt_r, filt_nxt;
  logic [6:0] tgt_l, tgt_r;
  logic step_ok, done, fx_change;
  logic signed [16:0] mono;
  logic signed [31:0] mix_l, mix_r;

  dpve_coef_mem u_coef (
    .ref_clk(ref_clk),
    .we(coef_we),
    .waddr(cidx_r),
    .wdata({wdata, coef_lo_r}),
    .raddr(cidx_r),
    .rdata(coef_q)
  );

  // ************************************************************
  // register port
  // ************************************************************
  always_comb begin
    vol_l_nxt = vol_l_r;
    vol_r_nxt = vol_r_r;
    eff_nxt = eff_r;
    pwr_nxt = pwr_r;
    atten_nxt = atten_r;
    div_nxt = div_r;
    bias_nxt = bias_r;
    coef_lo_nxt = coef_lo_r;
    cidx_nxt = cidx_r;
    coef_we = 1'b0;
    rdata_nxt = 8'h00;
    if (wr) begin
      case (addr)
        dpve_pkg::REG_VOL_LEFT: vol_l_nxt = wdata;
        dpve_pkg::REG_VOL_RIGHT: vol_r_nxt = wdata;
        dpve_pkg::REG_VOL_MASTER: begin
          vol_l_nxt = wdata;
          vol_r_nxt = wdata;
        end
        dpve_pkg::REG_EFFECT_CTRL: eff_nxt = wdata;
        dpve_pkg::REG_POWER_CTRL: pwr_nxt = wdata;
        dpve_pkg::REG_ATTEN_3D: atten_nxt = wdata;
        dpve_pkg::REG_RATE_DIV: div_nxt = wdata;
        dpve_pkg::REG_BIAS_CURRENT: bias_nxt = wdata;
        dpve_pkg::REG_COEF_LO: coef_lo_nxt = wdata;
        dpve_pkg::REG_COEF_HI: coef_we = 1'b1;
        dpve_pkg::REG_COEF_IDX: cidx_nxt = wdata[3:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        dpve_pkg::REG_VOL_LEFT: rdata_nxt = vol_l_r;
        dpve_pkg::REG_VOL_RIGHT: rdata_nxt = vol_r_r;
        dpve_pkg::REG_VOL_MASTER: rdata_nxt = vol_l_r;
        dpve_pkg::REG_EFFECT_CTRL: rdata_nxt = eff_r;
        dpve_pkg::REG_POWER_CTRL: rdata_nxt = pwr_r;
        dpve_pkg::REG_ATTEN_3D: rdata_nxt = atten_r;
        dpve_pkg::REG_RATE_DIV: rdata_nxt = div_r;
        dpve_pkg::REG_BIAS_CURRENT: rdata_nxt = bias_r;
        dpve_pkg::REG_COEF_LO: rdata_nxt = coef_q[7:0];
        dpve_pkg::REG_COEF_HI: rdata_nxt = coef_q[15:8];
        dpve_pkg::REG_COEF_IDX: rdata_nxt = {4'h0, cidx_r};
        dpve_pkg::REG_STATUS: begin
          rdata_nxt[dpve_pkg::ST_DONE_BIT] = done;
          rdata_nxt[dpve_pkg::ST_PDOWN_BIT] = pdown_r;
          rdata_nxt[dpve_pkg::ST_EFFECTS_BIT] = (state_r == ST_RUN);
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // soft-step sequencer
  // ************************************************************
  // targets: code 0 = 0 dB, each code cuts gain by 1/128 of full scale, mute forces full attenuation
  always_comb begin
    tgt_l = vol_l_r[dpve_pkg::VOL_MUTE_BIT] ? dpve_pkg::VOL_MUTE_CODE : vol_l_r[6:0];
    tgt_r = vol_r_r[dpve_pkg::VOL_MUTE_BIT] ? dpve_pkg::VOL_MUTE_CODE : vol_r_r[6:0];
    if (state_r != ST_RUN) begin
      tgt_l = dpve_pkg::VOL_MUTE_CODE;
      tgt_r = dpve_pkg::VOL_MUTE_CODE;
    end
    done = (app_l_r == tgt_l) && (app_r_r == tgt_r);
    fx_change = (eff_r[2:0] != fx_act_r);
  end

  always_comb begin
    state_nxt = state_r;
    fx_act_nxt = fx_act_r;
    pdown_nxt = pdown_r;
    slow_nxt = slow_r;
    app_l_nxt = app_l_r;
    app_r_nxt = app_r_r;
    step_ok = sample_valid && (!eff_r[dpve_pkg::EFF_SLOW_BIT] || slow_r);
    if (sample_valid) begin
      slow_nxt = ~slow_r;
    end
    if (eff_r[dpve_pkg::EFF_NORAMP_BIT]) begin
      app_l_nxt = tgt_l;
      app_r_nxt = tgt_r;
    end else if (step_ok) begin
      if (app_l_r < tgt_l) app_l_nxt = app_l_r + 7'h01;
      else if (app_l_r > tgt_l) app_l_nxt = app_l_r - 7'h01;
      if (app_r_r < tgt_r) app_r_nxt = app_r_r + 7'h01;
      else if (app_r_r > tgt_r) app_r_nxt = app_r_r - 7'h01;
    end
    case (state_r)
      ST_OFF: begin
        if (pwr_r[dpve_pkg::PWR_DAC_BIT]) begin
          state_nxt = ST_UP;
          pdown_nxt = 1'b0;
          fx_act_nxt = eff_r[2:0];
        end
      end
      ST_UP: state_nxt = ST_RUN;
      ST_RUN: begin
        if (!pwr_r[dpve_pkg::PWR_DAC_BIT]) state_nxt = ST_PDOWN;
        else if (fx_change) state_nxt = ST_FX_DOWN;
      end
      ST_FX_DOWN: begin
        if (done) begin
          fx_act_nxt = eff_r[2:0];
          state_nxt = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (done) begin
          pdown_nxt = 1'b1;
          state_nxt = ST_OFF;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // ************************************************************
  // datapath: 3-d mix, volume, rate hold, modulator
  // ************************************************************
  always_comb begin
    filt_nxt = filt_r;
    out_nxt = out_r;
    out_v_nxt = 1'b0;
    divc_nxt = divc_r;
    mono = (17'(sample_in.left) + 17'(sample_in.right)) >>> 1;
    mix_l = 32'(sample_in.left);
    mix_r = 32'(sample_in.right);
    if (fx_act_r[dpve_pkg::EFF_3D_BIT]) begin
      mix_l = mix_l + ((32'(filt_r) * $signed({24'h000000, atten_r})) >>> 8);
      mix_r = mix_r + ((32'(filt_r) * $signed({24'h000000, atten_r})) >>> 8);
    end
    if (sample_valid) begin
      filt_nxt = fx_act_r[dpve_pkg::EFF_FILTER_BIT]
        ? 16'((32'($signed(mono[15:0])) * 32'($signed(coef_q))) >>> 15) : mono[15:0];
      divc_nxt = (divc_r == 8'h00) ? div_r - 8'h01 : divc_r - 8'h01;
      if (divc_r == 8'h00) begin
        out_v_nxt = 1'b1;
        out_nxt.left = 16'((mix_l * 32'(8'h80 - {1'b0, app_l_r})) >>> 7);
        out_nxt.right = 16'((mix_r * 32'(8'h80 - {1'b0, app_r_r})) >>> 7);
        if (app_l_r == dpve_pkg::VOL_MUTE_CODE) out_nxt.left = '0;
        if (app_r_r == dpve_pkg::VOL_MUTE_CODE) out_nxt.right = '0;
      end
    end
    // first-order shaping per channel; held sample feeds each oversampled tick
    acc_l_nxt = acc_l_r + {2'b00, out_r.left ^ 16'h8000};
    acc_r_nxt = acc_r_r + {2'b00, out_r.right ^ 16'h8000};
    mod_l_nxt = acc_l_nxt[17:16];
    mod_r_nxt = acc_r_nxt[17:16];
    acc_l_nxt[17:16] = 2'b00;
    acc_r_nxt[17:16] = 2'b00;
  end

  // ************************************************************
  // flip-flops
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_OFF;
      vol_l_r <= 8'h00;
      vol_r_r <= 8'h00;
      eff_r <= 8'h00;
      pwr_r <= 8'h00;
      atten_r <= dpve_pkg::ATTEN_RESET;
      div_r <= dpve_pkg::RATE_DIV_RESET;
      bias_r <= dpve_pkg::BIAS_RESET;
      coef_lo_r <= 8'h00;
      cidx_r <= 4'h0;
      rdata <= 8'h00;
      fx_act_r <= 3'h0;
      app_l_r <= dpve_pkg::VOL_MUTE_CODE;
      app_r_r <= dpve_pkg::VOL_MUTE_CODE;
      slow_r <= 1'b0;
      pdown_r <= 1'b1;
      divc_r <= 8'h00;
      filt_r <= 16'sh0000;
      out_r <= '0;
      out_v_r <= 1'b0;
      acc_l_r <= 18'h00000;
      acc_r_r <= 18'h00000;
      mod_l_r <= 2'h0;
      mod_r_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      vol_l_r <= vol_l_nxt;
      vol_r_r <= vol_r_nxt;
      eff_r <= eff_nxt;
      pwr_r <= pwr_nxt;
      atten_r <= atten_nxt;
      div_r <= div_nxt;
      bias_r <= bias_nxt;
      coef_lo_r <= coef_lo_nxt;
      cidx_r <= cidx_nxt;
      rdata <= rdata_nxt;
      fx_act_r <= fx_act_nxt;
      app_l_r <= app_l_nxt;
      app_r_r <= app_r_nxt;
      slow_r <= slow_nxt;
      pdown_r <= pdown_nxt;
      divc_r <= divc_nxt;
      filt_r <= filt_nxt;
      out_r <= out_nxt;
      out_v_r <= out_v_nxt;
      acc_l_r <= acc_l_nxt;
      acc_r_r <= acc_r_nxt;
      mod_l_r <= mod_l_nxt;
      mod_r_r <= mod_r_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dac_power_on <= 1'b0;
      left_power_on <= 1'b0;
      right_power_on <= 1'b0;
      cm_level <= 2'h0;
      bias_current <= 2'h0;
    end else begin
      dac_power_on <= (state_nxt != ST_OFF);
      left_power_on <= (state_nxt != ST_OFF) && pwr_r[dpve_pkg::PWR_LEFT_BIT];
      right_power_on <= (state_nxt != ST_OFF) && pwr_r[dpve_pkg::PWR_RIGHT_BIT];
      cm_level <= pwr_r[dpve_pkg::PWR_CM_LSB +: 2];
      bias_current <= bias_r[dpve_pkg::BIAS_LSB +: 2];
    end
  end
  assign sample_out = out_r;
  assign sample_out_valid = out_v_r;
  assign mod_left = mod_l_r;
  assign mod_right = mod_r_r;
endmodule : dpve_playback

// ==== include/dpve_pkg.sv ====
/*
  package for the dac playback volume/effects block: register map, field layout,
  reset values, timing figures, carrier structs.
  assumes a 10 MHz ref_clk and a plain address/strobe register port.
*/
package dpve_pkg;
  // ************************************************************
  // register offsets (byte addresses, 8-bit registers)
  // ************************************************************
  localparam logic [7:0] REG_VOL_LEFT = 8'h40;
  localparam logic [7:0] REG_VOL_RIGHT = 8'h41;
  localparam logic [7:0] REG_VOL_MASTER = 8'h42;
  localparam logic [7:0] REG_EFFECT_CTRL = 8'h43;
  localparam logic [7:0] REG_POWER_CTRL = 8'h44;
  localparam logic [7:0] REG_STATUS = 8'h45;
  localparam logic [7:0] REG_ATTEN_3D = 8'h46;
  localparam logic [7:0] REG_RATE_DIV = 8'h47;
  localparam logic [7:0] REG_COEF_LO = 8'h48;
  localparam logic [7:0] REG_COEF_HI = 8'h49;
  localparam logic [7:0] REG_COEF_IDX = 8'h4a;
  localparam logic [7:0] REG_BIAS_CURRENT = 8'h6d;
  // ************************************************************
  // fields
  // ************************************************************
  localparam int VOL_W = 7;
  localparam logic [6:0] VOL_MUTE_CODE = 7'h7f;
  localparam int VOL_MUTE_BIT = 7;
  localparam int EFF_FILTER_BIT = 0;
  localparam int EFF_3D_BIT = 1;
  localparam int EFF_DEEMPH_BIT = 2;
  localparam int EFF_SLOW_BIT = 3;
  localparam int EFF_NORAMP_BIT = 4;
  localparam int PWR_DAC_BIT = 0;
  localparam int PWR_LEFT_BIT = 1;
  localparam int PWR_RIGHT_BIT = 2;
  localparam int PWR_CM_LSB = 4;
  localparam int BIAS_LSB = 6;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_PDOWN_BIT = 1;
  localparam int ST_EFFECTS_BIT = 2;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] RATE_DIV_RESET = 8'h01;
  localparam logic [7:0] ATTEN_RESET = 8'h00;
  localparam int COEF_W = 16;
  localparam int COEF_N = 16;
  localparam int COEF_AW = 4;
  // ************************************************************
  // timing and datapath figures
  // ************************************************************
  localparam int CLK_MHZ = 10;
  localparam int GROUP_DELAY_SAMPLES = 21;
  localparam int OSR_REF = 128;
  localparam int IMAGE_REJECT_DB = 65;
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 20;
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } dpve_stereo_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dpve_bus_s;
endpackage : dpve_pkg

// ==== verilog/dpve_coef_mem.sv ====
/*
  coefficient store for the effects filter: 16 words of 16 bits.
  assumes a single writer on ref_clk; read data is registered.
*/
`timescale 1ns/10ps
module dpve_coef_mem (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem_r [0:15];
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end
endmodule : dpve_coef_mem

// ==== verification/dpve_playback_props.sv ====
/*
  port checker for the playback block.
  assumes it is bound to dpve_playback and sees only its ports.
*/
`timescale 1ns/10ps
module dpve_playback_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic sample_valid,
  input wire dpve_pkg::dpve_stereo_s sample_out,
  input wire logic sample_out_valid,
  input wire logic dac_power_on,
  input wire logic [1:0] cm_level,
  input wire logic [1:0] bias_current
);
  // ************************************************************
  // port properties
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    bias_current == 2'h0 && cm_level == 2'h0 && !dac_power_on)
    else $error("outputs not cleared by reset");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_bias_write: assert property (wr && addr == dpve_pkg::REG_BIAS_CURRENT |-> ##2
    bias_current == $past(wdata[7:6], 2)) else $error("bias field not applied");
  a_cm_write: assert property (wr && addr == dpve_pkg::REG_POWER_CTRL |-> ##2
    cm_level == $past(wdata[5:4], 2)) else $error("common-mode field not applied");
  a_bias_read: assert property (rd && addr == dpve_pkg::REG_BIAS_CURRENT |=>
    rdata[7:6] == bias_current) else $error("bias readback differs");
  a_unmapped_read: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_out_hold: assert property (!sample_out_valid |-> $stable(sample_out))
    else $error("output sample moved without valid");
  a_out_cause: assert property (sample_out_valid |-> $past(sample_valid))
    else $error("output valid without input sample");
  a_pdown_flag: assert property ($past(rd && addr == dpve_pkg::REG_STATUS) &&
    rdata[dpve_pkg::ST_PDOWN_BIT] |-> !dac_power_on) else $error("flag before power off");
  a_dac_on: assert property (wr && addr == dpve_pkg::REG_POWER_CTRL &&
    wdata[dpve_pkg::PWR_DAC_BIT] |-> ##[1:2] dac_power_on) else $error("dac not powered");
endmodule : dpve_playback_props

// ==== verification/dpve_sample_src.sv ====
/*
  host audio source: one stereo sample every eight cycles while run is high.
  assumes ref_clk and rst of the bench; data lines toggle between samples.
*/
`timescale 1ns/10ps
module dpve_sample_src (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  output logic sample_valid,
  output dpve_pkg::dpve_stereo_s sample_in
);
  // ************************************************************
  // sample pacing
  // ************************************************************
  logic [2:0] gap_r;
  logic [15:0] cnt_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gap_r <= 3'h0;
      cnt_r <= 16'h1000;
      sample_valid <= 1'b0;
      sample_in <= '0;
    end else begin
      gap_r <= gap_r + 3'h1;
      sample_valid <= run && gap_r == 3'h7;
      if (run && gap_r == 3'h7) begin
        cnt_r <= cnt_r + 16'h0011;
        sample_in <= {cnt_r, 16'h0 - cnt_r};
      end else begin
        sample_in <= ~sample_in;
      end
    end
  end
endmodule : dpve_sample_src

// ==== verification/dpve_playback_tb_top.sv ====
/*
  self-checking bench for the playback block.
  assumes a 10 MHz ref_clk and the register map of the package.
*/
`timescale 1ns/10ps
module dpve_playback_tb_top;
  // ************************************************************
  // signals, instances, tasks
  // ************************************************************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b0;
  logic [7:0] rdata;
  logic sample_valid;
  dpve_pkg::dpve_stereo_s sample_in;
  dpve_pkg::dpve_stereo_s sample_out;
  logic sample_out_valid;
  logic [1:0] mod_left;
  logic [1:0] mod_right;
  logic [1:0] cm_level;
  logic [1:0] bias_current;
  logic dac_power_on;
  logic left_power_on;
  logic right_power_on;
  int num_errors = 0;
  int num_checks = 0;
  int n_out = 0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sample_out_valid === 1'b1) n_out <= n_out + 1;
  dpve_sample_src u_dpve_sample_src (.ref_clk(ref_clk), .rst(rst), .run(run),
    .sample_valid(sample_valid), .sample_in(sample_in));
  dpve_playback u_dpve_playback (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_valid(sample_valid),
    .sample_in(sample_in), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
    .mod_left(mod_left), .mod_right(mod_right), .dac_power_on(dac_power_on),
    .left_power_on(left_power_on), .right_power_on(right_power_on),
    .cm_level(cm_level), .bias_current(bias_current));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check(32'(rdata & m), 32'(e));
  endtask : rd_chk
  task automatic samples(input int n);
    repeat (n) begin
      do @(posedge ref_clk); while (sample_valid !== 1'b1);
    end
  endtask : samples
  task automatic t_regs();
    rd_chk(dpve_pkg::REG_BIAS_CURRENT, 8'hff, dpve_pkg::BIAS_RESET);
    wr_reg(dpve_pkg::REG_BIAS_CURRENT, 8'hc0);
    rd_chk(dpve_pkg::REG_BIAS_CURRENT, 8'hc0, 8'hc0);
    check(32'(bias_current), 32'h3);
    rd_chk(8'h00, 8'hff, 8'h00);
    wr_reg(dpve_pkg::REG_VOL_MASTER, 8'h05);
    rd_chk(dpve_pkg::REG_VOL_LEFT, 8'hff, 8'h05);
    rd_chk(dpve_pkg::REG_VOL_RIGHT, 8'hff, 8'h05);
    $display("test regs done");
  endtask : t_regs
  task automatic t_power();
    for (int c = 0; c < 4; c++) begin
      wr_reg(dpve_pkg::REG_POWER_CTRL, 8'(c * 16 + 7));
      @(posedge ref_clk);
      #1;
      check(32'(cm_level), 32'(c));
      check(32'({dac_power_on, left_power_on, right_power_on}), 32'h7);
    end
    wr_reg(dpve_pkg::REG_POWER_CTRL, 8'h03);
    repeat (2) @(posedge ref_clk);
    check(32'({left_power_on, right_power_on}), 32'h2);
    wr_reg(dpve_pkg::REG_POWER_CTRL, 8'h07);
    samples(2);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h00);
    $display("test power done");
  endtask : t_power
  task automatic t_ramp();
    wr_reg(dpve_pkg::REG_EFFECT_CTRL, 8'h10);
    wr_reg(dpve_pkg::REG_VOL_MASTER, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h01);
    wr_reg(dpve_pkg::REG_EFFECT_CTRL, 8'h00);
    wr_reg(dpve_pkg::REG_VOL_MASTER, 8'h04);
    samples(3);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h00);
    samples(2);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h01);
    wr_reg(dpve_pkg::REG_EFFECT_CTRL, 8'h08);
    wr_reg(dpve_pkg::REG_VOL_MASTER, 8'h00);
    samples(6);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h00);
    samples(4);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h01);
    wr_reg(dpve_pkg::REG_EFFECT_CTRL, 8'h00);
    $display("test ramp done");
  endtask : t_ramp
  task automatic t_mute();
    int n;
    wr_reg(dpve_pkg::REG_VOL_MASTER, 8'h80);
    samples(202);
    #1;
    check(sample_out, 32'h0);
    @(posedge ref_clk);
    #1;
    n = mod_left + mod_right;
    @(posedge ref_clk);
    #1;
    check(32'(n + mod_left + mod_right), 32'h2);
    wr_reg(dpve_pkg::REG_VOL_MASTER, 8'h00);
    samples(200);
    $display("test mute done");
  endtask : t_mute
  task automatic t_switch();
    wr_reg(dpve_pkg::REG_EFFECT_CTRL, 8'h01);
    samples(4);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h00);
    samples(300);
    rd_chk(dpve_pkg::REG_STATUS, 8'h01, 8'h01);
    wr_reg(dpve_pkg::REG_EFFECT_CTRL, 8'h00);
    wr_reg(dpve_pkg::REG_COEF_IDX, 8'h03);
    wr_reg(dpve_pkg::REG_COEF_LO, 8'h00);
    wr_reg(dpve_pkg::REG_COEF_HI, 8'h80);
    rd_chk(dpve_pkg::REG_COEF_LO, 8'hff, 8'h00);
    rd_chk(dpve_pkg::REG_COEF_HI, 8'hff, 8'h80);
    wr_reg(dpve_pkg::REG_EFFECT_CTRL, 8'h01);
    samples(300);
    $display("test switch done");
  endtask : t_switch
  task automatic t_rate();
    int n0;
    wr_reg(dpve_pkg::REG_RATE_DIV, 8'h03);
    samples(1);
    repeat (2) @(posedge ref_clk);
    n0 = n_out;
    samples(6);
    repeat (2) @(posedge ref_clk);
    check(32'(n_out - n0), 32'h2);
    wr_reg(dpve_pkg::REG_RATE_DIV, 8'h01);
    $display("test rate done");
  endtask : t_rate
  task automatic t_pdown();
    wr_reg(dpve_pkg::REG_POWER_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk);
    rd_chk(dpve_pkg::REG_STATUS, 8'h02, 8'h00);
    check(32'(dac_power_on), 32'h1);
    samples(300);
    rd_chk(dpve_pkg::REG_STATUS, 8'h02, 8'h02);
    check(32'(dac_power_on), 32'h0);
    $display("test pdown done");
  endtask : t_pdown
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    #5000000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    run <= 1'b1;
    t_regs();
    t_power();
    t_ramp();
    t_mute();
    t_switch();
    t_rate();
    t_pdown();
    summarize();
  end
endmodule : dpve_playback_tb_top
bind dpve_playback dpve_playback_props u_dpve_playback_props (.ref_clk(ref_clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_valid(sample_valid),
  .sample_out(sample_out), .sample_out_valid(sample_out_valid),
  .dac_power_on(dac_power_on), .cm_level(cm_level), .bias_current(bias_current));
